/* inc/bias_leadoff_defines.svh */
// Offsets, reset values and field constants of the bias-drive and lead-off register bank
// Functional notes
// [R1] Register 0x0E selects negative inputs for bias drive
// [R2] Bit k drives channel k+1 negative input
// [R3] Missing channels on smaller builds are unavailable bits
// [R4] Register 0x0F enables positive lead-off detection
// [R5] Bit k enables channel k+1 positive detection
// [R6] Software ignores positive status unless enabled
// [R7] Register 0x10 enables negative lead-off detection
// [R8] Bit 7 channel 8, bit 0 channel 1
// [R9] Software ignores negative status unless enabled
// [R10] Register 0x11 sets per-channel excitation direction
// [R11] Direction 0 pulls positive high, negative low
// [R12] Status bit reads one when electrode off
// [R13] Reads return last written value or zero
`ifndef BIAS_LEADOFF_DEFINES_SVH
`define BIAS_LEADOFF_DEFINES_SVH

// =====================================================================
// Register indices; byte address is four times the index
`define IDX_BIAS_NEG_SEL 8'h0E
`define IDX_LOFF_POS_EN 8'h0F
`define IDX_LOFF_NEG_EN 8'h10
`define IDX_LEADOFF_DIRECTION_FLIP 8'h11
`define IDX_LOFF_POS_STAT 8'h12
`define IDX_LOFF_NEG_STAT 8'h13

// =====================================================================
// Reset values
`define RST_BIAS_NEG_SEL 8'h00
`define RST_LOFF_POS_EN 8'h00
`define RST_LOFF_NEG_EN 8'h00
`define RST_LEADOFF_DIRECTION_FLIP 8'h00

// =====================================================================
// Channel masks of the three builds
`define MASK_FOUR_CH 8'h0F
`define MASK_SIX_CH 8'h3F
`define MASK_EIGHT_CH 8'hFF

// =====================================================================
// AXI4-Lite response codes and bus sizes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_WIDTH 8
`define DATA_WIDTH 32

`endif

/* inc/bias_leadoff_pkg.sv */
// Types shared by the bias-drive and lead-off register bank
package bias_leadoff_pkg;

  // =====================================================================
  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_BIAS_NEG,
    SEL_LOFF_POS,
    SEL_LOFF_NEG,
    SEL_LEADOFF_DIRECTION_FLIP,
    SEL_STAT_POS,
    SEL_STAT_NEG
  } reg_sel_type;

  // =====================================================================
  // One bit per channel, bit 0 is channel 1
  typedef logic [7:0] chan_bits_type;

endpackage

/* hw/sync_two_stage.sv */
// Two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module sync_two_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_one_q <= '0;
      sync_out <= '0;
    end else begin
      stage_one_q <= async_in;
      sync_out <= stage_one_q;
    end
  end

endmodule

/* hw/leadoff_pull_decode.sv */
// Per-channel pull direction decode for the lead-off excitation
`timescale 1ns/10ps
module leadoff_pull_decode (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire bias_leadoff_pkg::chan_bits_type pos_enable,
  input wire bias_leadoff_pkg::chan_bits_type neg_enable,
  input wire bias_leadoff_pkg::chan_bits_type direction,
  output bias_leadoff_pkg::chan_bits_type pos_pull_high,
  output bias_leadoff_pkg::chan_bits_type pos_pull_low,
  output bias_leadoff_pkg::chan_bits_type neg_pull_high,
  output bias_leadoff_pkg::chan_bits_type neg_pull_low
);

  // One decode slice per channel
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pos_pull_high[ch] <= 1'b0;
          pos_pull_low[ch] <= 1'b0;
          neg_pull_high[ch] <= 1'b0;
          neg_pull_low[ch] <= 1'b0;
        end else begin
          pos_pull_high[ch] <= pos_enable[ch] & ~direction[ch]; // [R11]
          pos_pull_low[ch] <= pos_enable[ch] & direction[ch]; // [R11]
          neg_pull_high[ch] <= neg_enable[ch] & direction[ch]; // [R11]
          neg_pull_low[ch] <= neg_enable[ch] & ~direction[ch]; // [R11]
        end
      end
    end
  endgenerate

endmodule

/* hw/bias_leadoff_regs.sv */
// AXI4-Lite register bank for bias-drive selection and lead-off detection
`timescale 1ns/10ps
`include "bias_leadoff_defines.svh"
module bias_leadoff_regs #(
  parameter int CHANNELS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write address channel
  input wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [`DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [`DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Raw lead-off comparator levels, asynchronous
  input wire logic [7:0] leadoff_positive_off,
  input wire logic [7:0] leadoff_negative_off,
  // Control to the analog front end
  output bias_leadoff_pkg::chan_bits_type bias_drive_negative_select,
  output bias_leadoff_pkg::chan_bits_type leadoff_positive_enable,
  output bias_leadoff_pkg::chan_bits_type leadoff_negative_enable,
  output bias_leadoff_pkg::chan_bits_type leadoff_direction_flip,
  output bias_leadoff_pkg::chan_bits_type pos_pull_high,
  output bias_leadoff_pkg::chan_bits_type pos_pull_low,
  output bias_leadoff_pkg::chan_bits_type neg_pull_high,
  output bias_leadoff_pkg::chan_bits_type neg_pull_low
);

  // =====================================================================
  // Helper functions

  // Bits present on the selected build
  function automatic bias_leadoff_pkg::chan_bits_type build_mask(input int count);
    bias_leadoff_pkg::chan_bits_type mask;
    mask = `MASK_EIGHT_CH;
    if (count == 4) begin
      mask = `MASK_FOUR_CH; // [R3]
    end else if (count == 6) begin
      mask = `MASK_SIX_CH; // [R3]
    end
    return mask;
  endfunction

  // Address to register select, shared by reads and writes
  function automatic bias_leadoff_pkg::reg_sel_type decode_addr(input logic [`ADDR_WIDTH-1:0] addr);
    bias_leadoff_pkg::reg_sel_type sel;
    logic [7:0] idx;
    sel = bias_leadoff_pkg::SEL_NONE;
    idx = {2'h0, addr[7:2]};
    if (idx == `IDX_BIAS_NEG_SEL) begin
      sel = bias_leadoff_pkg::SEL_BIAS_NEG; // [R1]
    end else if (idx == `IDX_LOFF_POS_EN) begin
      sel = bias_leadoff_pkg::SEL_LOFF_POS; // [R4]
    end else if (idx == `IDX_LOFF_NEG_EN) begin
      sel = bias_leadoff_pkg::SEL_LOFF_NEG; // [R7]
    end else if (idx == `IDX_LEADOFF_DIRECTION_FLIP) begin
      sel = bias_leadoff_pkg::SEL_LEADOFF_DIRECTION_FLIP; // [R10]
    end else if (idx == `IDX_LOFF_POS_STAT) begin
      sel = bias_leadoff_pkg::SEL_STAT_POS;
    end else if (idx == `IDX_LOFF_NEG_STAT) begin
      sel = bias_leadoff_pkg::SEL_STAT_NEG;
    end
    return sel;
  endfunction

  // Only the read/write registers accept a write
  function automatic logic is_writable(input bias_leadoff_pkg::reg_sel_type sel);
    return (sel == bias_leadoff_pkg::SEL_BIAS_NEG) || (sel == bias_leadoff_pkg::SEL_LOFF_POS) ||
           (sel == bias_leadoff_pkg::SEL_LOFF_NEG) || (sel == bias_leadoff_pkg::SEL_LEADOFF_DIRECTION_FLIP);
  endfunction

  localparam bias_leadoff_pkg::chan_bits_type CHAN_MASK = build_mask(CHANNELS);

  // =====================================================================
  // Write channel holding state
  logic aw_held_q;
  logic [`ADDR_WIDTH-1:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  bias_leadoff_pkg::reg_sel_type wr_sel;
  bias_leadoff_pkg::chan_bits_type wr_value;
  logic wr_lane_ok;

  // Read channel state
  logic rvalid_q;
  logic [`DATA_WIDTH-1:0] rdata_q;
  logic [1:0] rresp_q;
  bias_leadoff_pkg::reg_sel_type rd_sel;
  bias_leadoff_pkg::chan_bits_type rd_value;

  // Register storage
  bias_leadoff_pkg::chan_bits_type bias_neg_q;
  bias_leadoff_pkg::chan_bits_type loff_pos_q;
  bias_leadoff_pkg::chan_bits_type loff_neg_q;
  bias_leadoff_pkg::chan_bits_type leadoff_direction_flip_q;

  // Synchronised comparator levels
  logic [7:0] pos_off_sync;
  logic [7:0] neg_off_sync;

  // =====================================================================
  // Handshake outputs; each channel is refused while a response waits
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write performed once both address and data are held
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_sel = decode_addr(aw_addr_q);
  assign wr_lane_ok = do_write & is_writable(wr_sel) & w_lane_q;
  assign wr_value = w_data_q & CHAN_MASK; // [R3]

  // =====================================================================
  // Write address capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data capture, only the low byte lane carries register bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response; unmapped or read-only targets answer with an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_writable(wr_sel) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // =====================================================================
  // Negative inputs routed into the bias-drive derivation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bias_neg_q <= `RST_BIAS_NEG_SEL; // [R1]
    end else if (wr_lane_ok && wr_sel == bias_leadoff_pkg::SEL_BIAS_NEG) begin
      bias_neg_q <= wr_value; // [R2] [R13]
    end
  end

  // Positive input lead-off enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loff_pos_q <= `RST_LOFF_POS_EN; // [R4]
    end else if (wr_lane_ok && wr_sel == bias_leadoff_pkg::SEL_LOFF_POS) begin
      loff_pos_q <= wr_value; // [R5] [R13]
    end
  end

  // Negative input lead-off enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loff_neg_q <= `RST_LOFF_NEG_EN; // [R7]
    end else if (wr_lane_ok && wr_sel == bias_leadoff_pkg::SEL_LOFF_NEG) begin
      loff_neg_q <= wr_value; // [R8] [R13]
    end
  end

  // Excitation direction per channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      leadoff_direction_flip_q <= `RST_LEADOFF_DIRECTION_FLIP; // [R10]
    end else if (wr_lane_ok && wr_sel == bias_leadoff_pkg::SEL_LEADOFF_DIRECTION_FLIP) begin
      leadoff_direction_flip_q <= wr_value; // [R10] [R13]
    end
  end

  // =====================================================================
  // Read mux over stored and status registers
  assign rd_sel = decode_addr(s_axi_araddr);

  always_comb begin
    rd_value = 8'h00;
    unique case (rd_sel)
      bias_leadoff_pkg::SEL_NONE: rd_value = 8'h00;
      bias_leadoff_pkg::SEL_BIAS_NEG: rd_value = bias_neg_q; // [R13]
      bias_leadoff_pkg::SEL_LOFF_POS: rd_value = loff_pos_q; // [R13]
      bias_leadoff_pkg::SEL_LOFF_NEG: rd_value = loff_neg_q; // [R13]
      bias_leadoff_pkg::SEL_LEADOFF_DIRECTION_FLIP: rd_value = leadoff_direction_flip_q; // [R13]
      bias_leadoff_pkg::SEL_STAT_POS: rd_value = pos_off_sync & CHAN_MASK; // [R12]
      bias_leadoff_pkg::SEL_STAT_NEG: rd_value = neg_off_sync & CHAN_MASK; // [R12]
      default: rd_value = 8'h00;
    endcase
  end

  // Read data and response, one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_value};
      rresp_q <= (rd_sel == bias_leadoff_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // =====================================================================
  // Comparator levels cross in through two flip-flops
  sync_two_stage #(
    .WIDTH(8)
  ) u_sync_pos (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(leadoff_positive_off),
    .sync_out(pos_off_sync)
  );

  sync_two_stage #(
    .WIDTH(8)
  ) u_sync_neg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(leadoff_negative_off),
    .sync_out(neg_off_sync)
  );

  // =====================================================================
  // Register values driven to the front end
  assign bias_drive_negative_select = bias_neg_q; // [R2]
  assign leadoff_positive_enable = loff_pos_q; // [R5]
  assign leadoff_negative_enable = loff_neg_q; // [R8]
  assign leadoff_direction_flip = leadoff_direction_flip_q;

  // Pull steering from enables and direction
  leadoff_pull_decode u_pull (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pos_enable(loff_pos_q),
    .neg_enable(loff_neg_q),
    .direction(leadoff_direction_flip_q),
    .pos_pull_high(pos_pull_high),
    .pos_pull_low(pos_pull_low),
    .neg_pull_high(neg_pull_high),
    .neg_pull_low(neg_pull_low)
  );

endmodule

/* dv/bias_leadoff_regs_assertions.sv */
// Concurrent checks on the ports of the bias and lead-off register bank
`timescale 1ns/10ps
module bias_leadoff_regs_assertions #(
  parameter int CHANNELS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bias_leadoff_pkg::chan_bits_type bias_drive_negative_select,
  input wire bias_leadoff_pkg::chan_bits_type leadoff_positive_enable,
  input wire bias_leadoff_pkg::chan_bits_type leadoff_negative_enable,
  input wire bias_leadoff_pkg::chan_bits_type leadoff_direction_flip,
  input wire bias_leadoff_pkg::chan_bits_type pos_pull_high,
  input wire bias_leadoff_pkg::chan_bits_type neg_pull_low
);
  localparam logic [7:0] MASK = 8'hFF >> (8 - CHANNELS);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // Write steps: both halves taken, then a stalled response
  sequence seq_wr_take(logic [5:0] idx);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && s_axi_awaddr[7:2] == idx;
  endsequence
  sequence seq_wr_stall;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // Both halves are held one cycle, so the store and the response land two edges after the take
  chk_bias_store: assert property (seq_wr_take(6'h0E) |-> ##2 s_axi_bvalid
    && s_axi_bresp == 2'h0 && bias_drive_negative_select == ($past(s_axi_wdata[7:0], 2) & MASK))
    else $error("bias select not stored");
  chk_status_refused: assert property (seq_wr_take(6'h12) |-> ##2 s_axi_bresp == 2'h2
    && leadoff_positive_enable == $past(leadoff_positive_enable, 2)) else $error("status write not refused");
  chk_bresp_hold: assert property (seq_wr_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // =====================================================================
  // Read answer and hold
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:8] == 24'h000000) else $error("read answer late or wide");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h13
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("unmapped read not refused");
  // =====================================================================
  // Pull direction follows enable and flip one cycle later
  chk_pos_pull: assert property (1'b1 |=> pos_pull_high
    == ($past(leadoff_positive_enable) & ~$past(leadoff_direction_flip))) else $error("positive pull wrong");
  chk_neg_pull: assert property (1'b1 |=> neg_pull_low
    == ($past(leadoff_negative_enable) & ~$past(leadoff_direction_flip))) else $error("negative pull wrong");
endmodule

bind bias_leadoff_regs bias_leadoff_regs_assertions #(.CHANNELS(CHANNELS)) i_bias_leadoff_regs_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bias_drive_negative_select(bias_drive_negative_select), .leadoff_positive_enable(leadoff_positive_enable),
  .leadoff_negative_enable(leadoff_negative_enable), .leadoff_direction_flip(leadoff_direction_flip),
  .pos_pull_high(pos_pull_high), .neg_pull_low(neg_pull_low));

/* dv/tb.sv */
// Self-checking bench of the bias and lead-off register bank
`timescale 1ns/10ps
`include "bias_leadoff_defines.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pos_off = 8'h00, neg_off = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  bias_leadoff_pkg::chan_bits_type sel, pen, nen, flip, pph, ppl, nph, npl, sel_six;
  int checks = 0;
  int n_fail = 0;
  // =====================================================================
  // Full build and a six-channel build on the same bus inputs
  bias_leadoff_regs i_bias_leadoff_regs (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .leadoff_positive_off(pos_off), .leadoff_negative_off(neg_off), .bias_drive_negative_select(sel),
    .leadoff_positive_enable(pen), .leadoff_negative_enable(nen), .leadoff_direction_flip(flip),
    .pos_pull_high(pph), .pos_pull_low(ppl), .neg_pull_high(nph), .neg_pull_low(npl));
  bias_leadoff_regs #(.CHANNELS(6)) i_bias_leadoff_regs_six (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(s_axi_rready), .leadoff_positive_off(pos_off),
    .leadoff_negative_off(neg_off), .bias_drive_negative_select(sel_six), .leadoff_positive_enable(),
    .leadoff_negative_enable(), .leadoff_direction_flip(), .pos_pull_high(), .pos_pull_low(),
    .neg_pull_high(), .neg_pull_low());
  // 200 MHz clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // =====================================================================
  // Helpers
  function automatic logic [7:0] a4(input logic [7:0] idx);
    return idx << 2;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    check("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    check("rdata", ed, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask
  // =====================================================================
  // Scenarios
  task automatic test_reset;
    for (int i = 0; i < 4; i++) begin
      rdc(a4(8'(`IDX_BIAS_NEG_SEL + i)), 32'h0, 2'h0);
    end
    check("reset ports", 32'h0, {sel, pen, nen, flip});
  endtask
  task automatic test_readback;
    logic [7:0] v [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
    for (int i = 0; i < 4; i++) begin
      wrc(a4(8'(`IDX_BIAS_NEG_SEL + i)), {24'hFFFFFF, v[i]}, 4'hF, 2'h0);
      rdc(a4(8'(`IDX_BIAS_NEG_SEL + i)), {24'h0, v[i]}, 2'h0);
    end
    check("reg ports", {v[0], v[1], v[2], v[3]}, {sel, pen, nen, flip});
    wrc(a4(`IDX_BIAS_NEG_SEL), 32'hFF, 4'h0, 2'h0);
    rdc(a4(`IDX_BIAS_NEG_SEL), 32'h81, 2'h0);
  endtask
  // Enables stay set afterwards, so the later status reads are meaningful
  task automatic test_pull;
    logic [7:0] f [2] = '{8'h0F, 8'hF0};
    wrc(a4(`IDX_LOFF_POS_EN), 32'hFF, 4'h1, 2'h0);
    wrc(a4(`IDX_LOFF_NEG_EN), 32'hFF, 4'h1, 2'h0);
    for (int i = 0; i < 2; i++) begin
      wrc(a4(`IDX_LEADOFF_DIRECTION_FLIP), {24'h0, f[i]}, 4'h1, 2'h0);
      repeat (2) @(posedge clk_sys);
      check("pulls", {~f[i], f[i], f[i], ~f[i]}, {pph, ppl, nph, npl});
    end
  endtask
  task automatic test_status;
    pos_off <= 8'h96;
    neg_off <= 8'h69;
    repeat (3) @(posedge clk_sys);
    rdc(a4(`IDX_LOFF_POS_STAT), 32'h96, 2'h0);
    rdc(a4(`IDX_LOFF_NEG_STAT), 32'h69, 2'h0);
  endtask
  task automatic test_errors;
    rdc(8'h50, 32'h0, 2'h2);
    wrc(a4(`IDX_LOFF_POS_STAT), 32'h55, 4'h1, 2'h2);
    rdc(a4(`IDX_LOFF_POS_STAT), 32'h96, 2'h0);
    wrc(8'h00, 32'h55, 4'h1, 2'h2);
  endtask
  task automatic test_variant;
    wrc(a4(`IDX_BIAS_NEG_SEL), 32'hFF, 4'h1, 2'h0);
    check("eight build", 32'hFF, sel);
    check("six build", 32'h3F, sel_six);
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    test_reset;
    test_readback;
    test_pull;
    test_status;
    test_errors;
    test_variant;
    complete_run;
  end
  // Watchdog against a hung handshake
  initial begin
    #50000;
    n_fail++;
    complete_run;
  end
endmodule
